// ==== design/pad_ctrl_pkg.sv ====
`default_nettype none
package pad_ctrl_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int NUM_REGS = 10;
    localparam int NUM_NIBBLES = 24;
    localparam int NUM_PINS = 96;
    localparam int PINS_PER_NIBBLE = 4;
    localparam int REG_W = 16;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_PORT0_LOW = 16'hF080;
    localparam logic [15:0] IDX_PORT0_HIGH = 16'hF082;
    localparam logic [15:0] IDX_PORT1_LOW = 16'hF084;
    localparam logic [15:0] IDX_PORT1_HIGH = 16'hF086;
    localparam logic [15:0] IDX_PORT2 = 16'hF088;
    localparam logic [15:0] IDX_PORT3 = 16'hF08A;
    localparam logic [15:0] IDX_PORT4 = 16'hF08C;
    localparam logic [15:0] IDX_PORT6 = 16'hF08E;
    localparam logic [15:0] IDX_PORT7 = 16'hF090;
    localparam logic [15:0] IDX_PORT8 = 16'hF092;

    localparam logic [15:0] REG_IDX [NUM_REGS] = '{
        IDX_PORT0_LOW, IDX_PORT0_HIGH, IDX_PORT1_LOW, IDX_PORT1_HIGH, IDX_PORT2,
        IDX_PORT3, IDX_PORT4, IDX_PORT6, IDX_PORT7, IDX_PORT8};

    // Implemented bits: 8-pin ports hold two nibble pairs, 16-pin ports four.
    localparam logic [15:0] MASK_8PIN = 16'h00FF;
    localparam logic [15:0] MASK_16PIN = 16'hFFFF;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int REG_PORT2 = 4;
    localparam int REG_PORT3 = 5;

    // Port 3 pin 14 has no pad; its control outputs stay low.
    localparam logic [NUM_PINS-1:0] PIN_IMPL_MASK = 96'hFFFF_FFFF_BFFF_FFFF_FFFF_FFFF;

    // ---------------------------------------------------------------
    // Field encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_FAST = 2'b00,
        EDGE_SLOW = 2'b01,
        EDGE_RSVD2 = 2'b10,
        EDGE_RSVD3 = 2'b11
    } edge_rate_e;

    typedef enum logic [1:0] {
        DRIVE_MAX = 2'b00,
        DRIVE_DYNAMIC = 2'b01,
        DRIVE_REDUCED = 2'b10,
        DRIVE_RSVD = 2'b11
    } drive_strength_e;

    // One nibble pair: drive strength in the upper two bits, edge rate in the lower two.
    typedef struct packed {
        drive_strength_e nibble_drive_strength_field;
        edge_rate_e nibble_edge_rate_field;
    } nibble_ctrl_s;

    // Per-pin pad control handed to the analog pads.
    typedef struct packed {
        logic slow_edge;
        logic reduced_drive;
    } pad_ctrl_s;

    function automatic logic [15:0] reg_mask(input int r);
        reg_mask = (r == REG_PORT2 || r == REG_PORT3) ? MASK_16PIN : MASK_8PIN;
    endfunction : reg_mask

    // Maps a flat nibble number to its register; registers 4 and 5 hold four nibbles.
    function automatic int nib_reg(input int g);
        if (g < 8) begin
            nib_reg = g / 2;
        end else if (g < 16) begin
            nib_reg = REG_PORT2 + (g - 8) / 4;
        end else begin
            nib_reg = REG_PORT3 + 1 + (g - 16) / 2;
        end
    endfunction : nib_reg

    function automatic int nib_pos(input int g);
        if (g < 8) begin
            nib_pos = g % 2;
        end else if (g < 16) begin
            nib_pos = (g - 8) % 4;
        end else begin
            nib_pos = (g - 16) % 2;
        end
    endfunction : nib_pos

endpackage : pad_ctrl_pkg
`default_nettype wire

// ==== design/nibble_pad_ctrl.sv ====
`default_nettype none
module nibble_pad_ctrl
    import pad_ctrl_pkg::*;
#(
    parameter int PINS = 4
) (
    // Nibble field pair.
    input wire pad_ctrl_pkg::nibble_ctrl_s ctrl_i,
    // Pin driven value and sensed level.
    input wire logic [PINS-1:0] pin_out_i,
    input wire logic [PINS-1:0] pin_level_i,
    // Pad controls.
    output pad_ctrl_pkg::pad_ctrl_s [PINS-1:0] pad_o
);
    import pad_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    // Reserved codes are stored but treated as the reset choice, so a stray write never
    // leaves a pad in an undefined state.
    wire slow_sel = (ctrl_i.nibble_edge_rate_field == EDGE_SLOW);
    wire dyn_sel = (ctrl_i.nibble_drive_strength_field == DRIVE_DYNAMIC);
    wire low_sel = (ctrl_i.nibble_drive_strength_field == DRIVE_REDUCED);

    // Dynamic mode drops to reduced strength once the pin has reached its target level.
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        assign pad_o[p].slow_edge = slow_sel;
        assign pad_o[p].reduced_drive = low_sel ||
                                        (dyn_sel && (pin_level_i[p] == pin_out_i[p]));
    end

endmodule : nibble_pad_ctrl
`default_nettype wire

// ==== design/pad_driver_control_regs.sv ====
// Local design decision: register access over APB.
`default_nettype none
module pad_driver_control_regs
    import pad_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pad side.
    input wire logic [pad_ctrl_pkg::NUM_PINS-1:0] pin_out_i,
    input wire logic [pad_ctrl_pkg::NUM_PINS-1:0] pin_level_i,
    output logic [pad_ctrl_pkg::NUM_PINS-1:0] pad_slow_edge_o,
    output logic [pad_ctrl_pkg::NUM_PINS-1:0] pad_reduced_drive_o
);
    import pad_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic [REG_W-1:0] ctrl_reg [NUM_REGS];
    logic [31:0] prdata_reg;
    logic [NUM_REGS-1:0] hit;
    logic [REG_W-1:0] rd_mux;
    logic [NUM_PINS-1:0] slow_reg;
    logic [NUM_PINS-1:0] reduced_reg;
    pad_ctrl_s [NUM_PINS-1:0] pad_next;

    // One hit line per register; the byte address is the index shifted up by two.
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_dec
        assign hit[r] = (paddr_i == {14'h0000, REG_IDX[r], 2'b00});
    end

    wire mapped = |hit;
    wire setup_ph = psel_i && !penable_i;
    wire access_ph = psel_i && penable_i;
    wire wr_en = access_ph && pwrite_i && mapped;

    // Zero wait states: read data was captured in the setup cycle.
    assign pready_o = 1'b1;
    assign pslverr_o = access_ph && !mapped;
    assign prdata_o = prdata_reg;

    // Read mux; masking keeps unimplemented upper bits at zero.
    always_comb begin
        rd_mux = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (hit[r]) begin
                rd_mux = ctrl_reg[r] & reg_mask(r);
            end
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    // Byte lanes apply per strobe; the mask drops writes into bits with no field.
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
        wire [REG_W-1:0] lane_mask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}} & reg_mask(r);
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                ctrl_reg[r] <= CTRL_RESET;
            end else if (wr_en && hit[r]) begin
                ctrl_reg[r] <= (ctrl_reg[r] & ~lane_mask) |
                               (pwdata_i[REG_W-1:0] & lane_mask);
            end
        end
    end

    // Read data is taken at setup so it stands through the access cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_ph && !pwrite_i) begin
            prdata_reg <= {16'h0000, rd_mux};
        end
    end

    // ---------------------------------------------------------------
    // Pad control
    // ---------------------------------------------------------------
    // Each nibble pair is sliced out of its register at bit 4*position.
    for (genvar g = 0; g < NUM_NIBBLES; g++) begin : g_nib
        localparam int RI = nib_reg(g);
        localparam int LSB = PINS_PER_NIBBLE * nib_pos(g);
        localparam int PB = PINS_PER_NIBBLE * g;
        nibble_ctrl_s nib;
        assign nib = ctrl_reg[RI][LSB+3:LSB];
        nibble_pad_ctrl #(
            .PINS(PINS_PER_NIBBLE)
        ) u_nib (
            .ctrl_i(nib),
            .pin_out_i(pin_out_i[PB+3:PB]),
            .pin_level_i(pin_level_i[PB+3:PB]),
            .pad_o(pad_next[PB+3:PB])
        );
    end

    // Pad controls are registered, so the dynamic drop lags the pin level by a cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            slow_reg <= '0;
            reduced_reg <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                slow_reg[p] <= pad_next[p].slow_edge && PIN_IMPL_MASK[p];
                reduced_reg[p] <= pad_next[p].reduced_drive && PIN_IMPL_MASK[p];
            end
        end
    end

    assign pad_slow_edge_o = slow_reg;
    assign pad_reduced_drive_o = reduced_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Bus steps that the properties below are built from.
    sequence s_write_port0;
        access_ph && pwrite_i && hit[0] && pstrb_i[0];
    endsequence

    sequence s_write_low(int r);
        access_ph && pwrite_i && hit[r] && pstrb_i[0];
    endsequence

    sequence s_write_hi16(int r);
        access_ph && pwrite_i && hit[r] && pstrb_i[1];
    endsequence

    sequence s_read_setup(int r);
        setup_ph && !pwrite_i && hit[r];
    endsequence

    sequence s_read_access;
        access_ph && !pwrite_i;
    endsequence

    sequence s_unmapped_write;
        access_ph && pwrite_i && !mapped;
    endsequence

    // Register writes: a strobed lane lands, an unstrobed or unmapped one leaves the word alone.
    a_upper_write_drop: assert property (
        s_write_port0 |=> ctrl_reg[0][15:8] == 8'h00)
        else $error("8-pin register kept upper bits");

    a_write_lands: assert property (
        s_write_port0 |=> ctrl_reg[0][7:0] == $past(pwdata_i[7:0]))
        else $error("8-pin register write lost");

    a_write_port8: assert property (
        s_write_low(9) |=> ctrl_reg[9][7:0] == $past(pwdata_i[7:0]))
        else $error("port 8 register write lost");

    a_upper_drop_port8: assert property (
        s_write_low(9) |=> ctrl_reg[9][15:8] == 8'h00)
        else $error("port 8 register kept upper bits");

    a_write_hi_port2: assert property (
        s_write_hi16(4) |=> ctrl_reg[4][15:8] == $past(pwdata_i[15:8]))
        else $error("port 2 upper byte write lost");

    a_write_hi_port3: assert property (
        s_write_hi16(5) |=> ctrl_reg[5][15:8] == $past(pwdata_i[15:8]))
        else $error("port 3 upper byte write lost");

    a_no_strobe_keep: assert property (
        access_ph && pwrite_i && hit[5] && !pstrb_i[0] |=> $stable(ctrl_reg[5][7:0]))
        else $error("unstrobed lane changed");

    a_unmapped_keep: assert property (
        s_unmapped_write |=> $stable(ctrl_reg[0]) && $stable(ctrl_reg[4]))
        else $error("unmapped write changed a register");

    // Register reads: data stands in the access cycle, unimplemented bits read zero.
    a_read_high_zero: assert property (
        s_read_setup(6) |=> prdata_o[15:8] == 8'h00)
        else $error("8-pin register read nonzero high byte");

    a_read_port0_high: assert property (
        s_read_setup(1) |=> prdata_o[15:8] == 8'h00)
        else $error("port 0 high register read nonzero high byte");

    a_read_upper_word: assert property (
        s_read_access |-> prdata_o[31:16] == 16'h0000)
        else $error("read data upper word nonzero");

    a_read_16_full: assert property (
        s_read_setup(4) ##1 access_ph |-> prdata_o[15:0] == ctrl_reg[4])
        else $error("16-pin register read mismatch");

    a_read_port8: assert property (
        s_read_setup(9) ##1 access_ph |-> prdata_o[7:0] == ctrl_reg[9][7:0])
        else $error("port 8 register read mismatch");

    a_unmapped_err: assert property (
        access_ph && !mapped |-> pslverr_o && pready_o)
        else $error("unmapped access not flagged");

    a_mapped_no_err: assert property (
        access_ph && mapped |-> !pslverr_o)
        else $error("mapped access flagged as error");

    // Edge-rate fields reach their implemented pins one cycle later; reserved codes act as fast.
    a_slow_edge_map: assert property (
        ctrl_reg[5][13:12] == EDGE_SLOW |=> pad_slow_edge_o[63] && !pad_slow_edge_o[62])
        else $error("slow edge not applied to nibble 3 of port 3");

    a_slow_port0: assert property (
        ctrl_reg[1][5:4] == EDGE_SLOW |=> pad_slow_edge_o[15:12] == 4'hF)
        else $error("slow edge not applied to port 0 high nibble 1");

    a_slow_port1_low: assert property (
        ctrl_reg[2][1:0] == EDGE_SLOW |=> pad_slow_edge_o[19:16] == 4'hF)
        else $error("slow edge not applied to port 1 low nibble 0");

    a_slow_port4: assert property (
        ctrl_reg[6][5:4] == EDGE_SLOW |=> pad_slow_edge_o[71:68] == 4'hF)
        else $error("slow edge not applied to port 4 nibble 1");

    a_slow_port2_top: assert property (
        ctrl_reg[4][13:12] == EDGE_SLOW |=> pad_slow_edge_o[47:44] == 4'hF)
        else $error("slow edge not applied to port 2 nibble 3");

    a_fast_edge_map: assert property (
        ctrl_reg[4][1:0] == EDGE_FAST |=> pad_slow_edge_o[35:32] == 4'h0)
        else $error("fast edge code drove slow pads");

    a_rsvd_edge_fast: assert property (
        ctrl_reg[7][1:0] == EDGE_RSVD2 |=> pad_slow_edge_o[75:72] == 4'h0)
        else $error("reserved edge code drove slow pads");

    a_rsvd_edge_hi: assert property (
        ctrl_reg[7][5:4] == EDGE_RSVD3 |=> pad_slow_edge_o[79:76] == 4'h0)
        else $error("reserved edge code drove slow pads");

    // Drive fields: the reduced code lowers the strength, dynamic lowers it only once the pin is at its target level, the others keep maximum.
    a_reduced_drive: assert property (
        ctrl_reg[0][3:2] == DRIVE_REDUCED |=> pad_reduced_drive_o[3:0] == 4'hF)
        else $error("reduced drive not applied");

    a_reduced_port1_high: assert property (
        ctrl_reg[3][7:6] == DRIVE_REDUCED |=> pad_reduced_drive_o[31:28] == 4'hF)
        else $error("reduced drive not applied to port 1 high nibble 1");

    a_drive_16_map: assert property (
        ctrl_reg[5][11:10] == DRIVE_REDUCED |=> pad_reduced_drive_o[59:56] == 4'hF)
        else $error("reduced drive not applied to port 3 nibble 2");

    a_max_drive: assert property (
        ctrl_reg[0][7:6] == DRIVE_MAX |=> pad_reduced_drive_o[7:4] == 4'h0)
        else $error("maximum drive reduced");

    a_rsvd_drive_max: assert property (
        ctrl_reg[8][3:2] == DRIVE_RSVD |=> pad_reduced_drive_o[83:80] == 4'h0)
        else $error("reserved drive code reduced the pads");

    a_dynamic_drive: assert property (
        ctrl_reg[9][3:2] == DRIVE_DYNAMIC && pin_level_i[88] != pin_out_i[88]
        |=> !pad_reduced_drive_o[88])
        else $error("dynamic drive reduced before target level");

    a_dynamic_settled: assert property (
        ctrl_reg[9][3:2] == DRIVE_DYNAMIC && pin_level_i[89] == pin_out_i[89]
        |=> pad_reduced_drive_o[89])
        else $error("dynamic drive kept full strength at target level");

    // The absent pin of port 3 never asks its pad for anything.
    a_missing_pin: assert property (
        !pad_slow_edge_o[62] && !pad_reduced_drive_o[62])
        else $error("absent pin control driven");

    // The first cycle after reset shows cleared fields and idle pads.
    a_reset_clear: assert property (
        $fell(rst_i) |-> ctrl_reg[2] == CTRL_RESET && ctrl_reg[5] == CTRL_RESET)
        else $error("register not cleared by reset");

    a_reset_pads: assert property (
        $fell(rst_i) |-> pad_slow_edge_o == '0 && pad_reduced_drive_o == '0)
        else $error("pad controls not cleared by reset");

endmodule : pad_driver_control_regs
`default_nettype wire

// ==== dv/pad_driver_control_regs_tb_top.sv ====
`default_nettype none
module pad_driver_control_regs_tb_top;
    import pad_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Stimulus signals and bookkeeping
    // ----------------------------------------------------------------
    typedef struct packed {
        logic chk;
        logic err;
        logic [31:0] d;
    } note_s;

    logic ref_clk_i = 1'b0;
    logic rst_i, psel_i, penable_i, pwrite_i;
    logic [31:0] paddr_i, pwdata_i, prdata_o;
    logic [3:0] pstrb_i;
    logic pready_o, pslverr_o;
    logic [95:0] pin_out_i, pin_level_i, pad_slow_edge_o, pad_reduced_drive_o, po;
    logic [15:0] m [10];
    note_s q [$];
    note_s nt;
    int errors = 0;
    int comparisons = 0;

    pad_driver_control_regs dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pin_out_i(pin_out_i), .pin_level_i(pin_level_i),
        .pad_slow_edge_o(pad_slow_edge_o), .pad_reduced_drive_o(pad_reduced_drive_o));

    // A 50 ns period gives the 20 MHz register clock.
    always #25 ref_clk_i = ~ref_clk_i;

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic compare(input logic [95:0] got, input logic [95:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : compare

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    // A negative index selects an unmapped word; the request is held until pready is seen.
    task automatic apb(input logic w, input int r, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] bm;
        int n;
        bm = {{8{s[1]}}, {8{s[0]}}};
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= (r >= 0) ? {14'h0000, REG_IDX[r], 2'h0} : 32'h0003_c204;
        pwdata_i <= d;
        pstrb_i <= s;
        q.push_back('{chk: !w && r >= 0, err: r < 0, d: (r >= 0) ? {16'h0000, m[r]} : 32'h0});
        if (w && r >= 0) begin
            m[r] = (m[r] & ~bm) | (d[15:0] & bm & ((r == 4 || r == 5) ? 16'hffff : 16'h00ff));
        end
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            report_and_stop();
        end
    endtask : apb

    task automatic idle;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : idle

    // Works out each pin's pad controls from the model and the held pin levels.
    task automatic check_pads(input string name);
        logic [95:0] es, er;
        logic [3:0] f;
        int r, pos;
        for (int p = 0; p < 96; p++) begin
            r = p < 32 ? p / 8 : (p < 64 ? 4 + (p - 32) / 16 : 6 + (p - 64) / 8);
            pos = (p >= 32 && p < 64) ? (p / 4) % 4 : (p / 4) % 2;
            f = m[r] >> (4 * pos);
            es[p] = (p != 62) && f[1:0] == 2'b01;
            er[p] = (p != 62) && (f[3:2] == 2'b10 || (f[3:2] == 2'b01 && pin_level_i[p] == po[p]));
        end
        compare(pad_slow_edge_o, es, "slow edge");
        compare(pad_reduced_drive_o, er, "reduced drive");
        $display("test %s done", name);
    endtask : check_pads

    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_i && psel_i && penable_i && pready_o === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("unexpected at %0t: transfer with no note", $time);
            end else begin
                nt = q.pop_front();
                compare(pslverr_o, nt.err, "error flag");
                if (nt.chk) compare(prdata_o, nt.d, "read data");
            end
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        rst_i = 1'b1;
        {pin_out_i, pin_level_i, po} = '0;
        foreach (m[i]) m[i] = 16'h0000;
        void'($urandom(32'h1835));
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (int r = 0; r < 10; r++) apb(1'b0, r, 32'h0, 4'hf);
        idle();
        check_pads("reset values");
        // Every code in every nibble, with the pins shuffled so dynamic drive sees both cases.
        for (int c = 0; c < 16; c++) begin
            for (int r = 0; r < 10; r++) apb(1'b1, r, {16'hffff, {4{c[3:0]}}}, 4'hf);
            for (int r = 0; r < 10; r++) apb(1'b0, r, 32'h0, 4'hf);
            idle();
            po = {$urandom, $urandom, $urandom};
            pin_out_i <= po;
            pin_level_i <= po ^ ({$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom});
            repeat (3) @(posedge ref_clk_i);
            check_pads("code sweep");
        end
        // Random data, refused accesses and a one-byte strobe, all back to back.
        for (int r = 0; r < 10; r++) apb(1'b1, r, $urandom, 4'hf);
        apb(1'b1, -1, $urandom, 4'hf);
        apb(1'b0, -1, 32'h0, 4'hf);
        apb(1'b1, 5, $urandom, 4'h2);
        for (int r = 0; r < 10; r++) apb(1'b0, r, 32'h0, 4'hf);
        idle();
        repeat (2) @(posedge ref_clk_i);
        check_pads("random data");
        // A second reset in mid-run must clear every field.
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (m[i]) m[i] = 16'h0000;
        @(posedge ref_clk_i);
        for (int r = 0; r < 10; r++) apb(1'b0, r, 32'h0, 4'hf);
        idle();
        check_pads("second reset");
        report_and_stop();
    end
endmodule : pad_driver_control_regs_tb_top
`default_nettype wire
